// [design/sfrs_pkg.sv]
// constants and state encoding for the serial flash reset sequencer
package sfrs_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWER_UP_DELAY_US = 300;
  localparam int WARM_RESET_DURATION_US = 35;
  localparam int RESET_PULSE_WIDTH_NS = 200;
  localparam int RESET_HOLD_TIME_NS = 50;
  localparam int RESET_SETUP_TIME_NS = 50;
  localparam int POWER_UP_CYCLES = (POWER_UP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARM_RESET_CYCLES =
    (WARM_RESET_DURATION_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYCLES = (RESET_PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 16;

  typedef enum logic [2:0] {
    SFRS_OFF = 3'b000,
    SFRS_COLD = 3'b001,
    SFRS_HELD = 3'b010,
    SFRS_WARM = 3'b011,
    SFRS_READY = 3'b100
  } sfrs_state_e;
endpackage : sfrs_pkg

// [design/sfrs_sequencer.sv]
// reset and power mode sequencer of the serial flash
`timescale 1ns/10ps
`default_nettype none
module sfrs_sequencer
  import sfrs_pkg::*;
#(
  parameter int POWER_UP_CYC = POWER_UP_CYCLES,
  parameter int WARM_RESET_CYC = WARM_RESET_CYCLES
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic supply_good_i,
  input wire logic reset_n_i,
  input wire logic chip_sel_n_i,
  input wire logic cold_start_ok_i,
  input wire logic soft_reset_cmd_i,
  input wire logic busy_i,
  output logic cmd_enable_o,
  output logic outputs_float_o,
  output logic abort_o,
  output logic regs_restore_o,
  output logic write_enable_latch_clr_o,
  output logic active_mode_o,
  output logic standby_mode_o
);
  logic [1:0] sync_pwr_reg, sync_rst_reg, sync_cs_reg;
  logic pwr_s, rst_n_s, cs_n_s;
  sfrs_state_e state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] low_reg, low_next;
  logic rst_prev_reg;
  logic cold_fail_reg, cold_fail_next;
  logic active_reg, active_next;
  logic abort_reg, abort_next;
  logic restore_reg, restore_next;
  logic wel_clr_reg, wel_clr_next;
  logic fall;

  // two flops before use; edge history taken from the second flop only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_pwr_reg <= 2'h0;
      sync_rst_reg <= 2'h3;
      sync_cs_reg <= 2'h3;
      rst_prev_reg <= 1'b1;
    end else begin
      sync_pwr_reg <= {sync_pwr_reg[0], supply_good_i};
      sync_rst_reg <= {sync_rst_reg[0], reset_n_i};
      sync_cs_reg <= {sync_cs_reg[0], chip_sel_n_i};
      rst_prev_reg <= sync_rst_reg[1];
    end
  end
  assign pwr_s = sync_pwr_reg[1];
  assign rst_n_s = sync_rst_reg[1];
  assign cs_n_s = sync_cs_reg[1];
  assign fall = rst_prev_reg && !rst_n_s;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cold_fail_next = cold_fail_reg;
    abort_next = 1'b0;
    restore_next = 1'b0;
    wel_clr_next = 1'b0;
    low_next = rst_n_s ? '0 : ((low_reg == '1) ? low_reg : low_reg + 1'b1);
    case (state_reg)
      SFRS_OFF: begin
        if (pwr_s) begin
          state_next = SFRS_COLD;
          cnt_next = '0;
        end
      end
      SFRS_COLD: begin
        // reset pin only looked at once the delay ends, to pick ready or held
        if (cnt_reg >= CNT_W'(POWER_UP_CYC - 1)) begin
          cold_fail_next = !cold_start_ok_i;
          wel_clr_next = 1'b1;
          cnt_next = '0;
          state_next = rst_n_s ? SFRS_READY : SFRS_HELD;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      SFRS_HELD: begin
        if (rst_n_s) state_next = SFRS_READY;
      end
      SFRS_WARM: begin
        if (cnt_reg >= CNT_W'(WARM_RESET_CYC - 1)) begin
          cnt_next = '0;
          state_next = rst_n_s ? SFRS_READY : SFRS_HELD;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      SFRS_READY: begin
        if ((!rst_n_s || soft_reset_cmd_i) && cold_fail_reg) begin
          state_next = SFRS_COLD;
          cnt_next = '0;
        end else if (fall || (!rst_n_s && low_reg == '0)) begin
          // warm reset begins at the fall; outputs float from then on
          state_next = SFRS_WARM;
          cnt_next = '0;
          restore_next = 1'b1;
          wel_clr_next = 1'b1;
        end
      end
      default: begin
        state_next = SFRS_OFF;
        cnt_next = '0;
      end
    endcase
    // abort pulse once the low level has lasted the pulse width
    if (low_reg == CNT_W'(PULSE_CYCLES - 1) && !rst_n_s &&
        (state_reg == SFRS_WARM || state_reg == SFRS_READY)) begin
      abort_next = 1'b1;
    end
    if (!pwr_s) begin
      state_next = SFRS_OFF;
      cnt_next = '0;
    end
    // stays active after deselect until busy work ends
    active_next = (state_reg == SFRS_READY) && (!cs_n_s || busy_i);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= SFRS_OFF;
      cnt_reg <= '0;
      low_reg <= '0;
      cold_fail_reg <= 1'b0;
      active_reg <= 1'b0;
      abort_reg <= 1'b0;
      restore_reg <= 1'b0;
      wel_clr_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      low_reg <= low_next;
      cold_fail_reg <= cold_fail_next;
      active_reg <= active_next;
      abort_reg <= abort_next;
      restore_reg <= restore_next;
      wel_clr_reg <= wel_clr_next;
    end
  end

  assign cmd_enable_o = (state_reg == SFRS_READY);
  assign outputs_float_o = (state_reg != SFRS_READY);
  assign abort_o = abort_reg;
  assign regs_restore_o = restore_reg;
  assign write_enable_latch_clr_o = wel_clr_reg;
  assign active_mode_o = active_reg;
  assign standby_mode_o = (state_reg == SFRS_READY) && !active_reg;

  a_cold_no_cmd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_reg == SFRS_COLD |-> !cmd_enable_o)
    else $error("command enabled during cold start");
  a_cold_ignores_pin: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_COLD && cnt_reg < CNT_W'(POWER_UP_CYC - 1) && pwr_s) |=>
    state_reg == SFRS_COLD)
    else $error("cold start cut short");
  a_held_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_HELD && !rst_n_s && pwr_s) |=> state_reg == SFRS_HELD)
    else $error("left reset hold while pin low");
  a_warm_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_READY && fall && !cold_fail_reg && pwr_s) |=>
    state_reg == SFRS_WARM && regs_restore_o)
    else $error("warm reset not started on fall");
  a_warm_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_WARM && cnt_reg == '0) |-> outputs_float_o && !cmd_enable_o)
    else $error("warm reset let commands through");
  a_fail_cold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_READY && cold_fail_reg && soft_reset_cmd_i && pwr_s) |=>
    state_reg == SFRS_COLD && cnt_reg == '0)
    else $error("failed cold start not restarted");
  a_active_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_READY && !cs_n_s) |=> active_mode_o)
    else $error("not active while selected");
  a_wel_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_COLD && $past(state_reg) == SFRS_COLD && state_next == SFRS_READY && pwr_s)
    |=> write_enable_latch_clr_o)
    else $error("write enable latch not cleared after power up");
  a_supply_loss: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !pwr_s |=> state_reg == SFRS_OFF)
    else $error("supply loss did not return to off");
  a_cold_enter: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_OFF && pwr_s) |=> state_reg == SFRS_COLD && cnt_reg == '0)
    else $error("cold start not entered on supply good");
  a_cold_end: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_COLD && cnt_reg >= CNT_W'(POWER_UP_CYC - 1) && pwr_s) |=>
    state_reg != SFRS_COLD)
    else $error("cold start overran its delay");
  a_warm_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_WARM && cnt_reg < CNT_W'(WARM_RESET_CYC - 1) && pwr_s) |=>
    state_reg == SFRS_WARM)
    else $error("warm reset cut short");
  a_held_exit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_HELD && rst_n_s && pwr_s) |=> state_reg == SFRS_READY)
    else $error("reset hold not left on pin high");
  a_fail_pin: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_READY && cold_fail_reg && !rst_n_s && pwr_s) |=>
    state_reg == SFRS_COLD && cnt_reg == '0)
    else $error("low pin after failed cold start did not restart it");
  a_fail_latch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_COLD && cnt_reg >= CNT_W'(POWER_UP_CYC - 1) && pwr_s &&
    !cold_start_ok_i) |=> cold_fail_reg)
    else $error("failed cold start not remembered");
  a_abort_time: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ((state_reg == SFRS_WARM || state_reg == SFRS_READY) && !rst_n_s &&
    low_reg == CNT_W'(PULSE_CYCLES - 1)) |=> abort_o)
    else $error("abort missing after pulse width");
  a_abort_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    abort_o |=> !abort_o)
    else $error("abort longer than one cycle");
  a_restore_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    regs_restore_o |=> !regs_restore_o)
    else $error("restore longer than one cycle");
  a_wel_warm: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_READY && fall && !cold_fail_reg && pwr_s) |=>
    write_enable_latch_clr_o)
    else $error("write enable latch not cleared on warm reset");
  a_active_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_READY && busy_i) |=> active_mode_o)
    else $error("not active while busy");
  a_standby_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (state_reg == SFRS_READY && cs_n_s && !busy_i) |=> !active_mode_o)
    else $error("still active when idle and deselected");
endmodule : sfrs_sequencer
`default_nettype wire

// [sim/sfrs_host_model.sv]
// host side model driving reset pin and chip select
`timescale 1ns/10ps
`default_nettype none
module sfrs_host_model #(
  parameter int HOLD_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_req_i,
  input wire logic sel_req_i,
  output logic reset_n_o,
  output logic chip_sel_n_o
);
  int cnt = 0;
  initial begin
    reset_n_o = 1'b1;
    chip_sel_n_o = 1'b1;
  end
  // one extra low cycle after release so the pulse is never cut short
  always @(posedge clk_i) begin
    if (rst_req_i) cnt <= HOLD_CYC + 1;
    else if (cnt > 0) cnt <= cnt - 1;
    reset_n_o <= !rst_req_i && cnt <= HOLD_CYC;
    chip_sel_n_o <= !(sel_req_i && !rst_req_i && cnt == 0);
  end
endmodule : sfrs_host_model
`default_nettype wire

// [sim/sfrs_sequencer_tb_top.sv]
// testbench of the serial flash reset sequencer
`timescale 1ns/10ps
`default_nettype none
module sfrs_sequencer_tb_top;
  localparam int PU = 50;
  localparam int WR = 40;
  logic clk_i = 0, sys_rst_i = 1, supply_good_i = 0, cold_start_ok_i = 1;
  logic soft_reset_cmd_i = 0, busy_i = 0, rst_req = 0, sel_req = 0;
  logic reset_n_i, chip_sel_n_i, cmd_enable_o, outputs_float_o, abort_o, regs_restore_o;
  logic write_enable_latch_clr_o, active_mode_o, standby_mode_o;
  int errors = 0, n_compared = 0, cyc = 0, ab = 0, rr = 0, wc = 0, n;
  always #5 clk_i = ~clk_i;
  sfrs_sequencer #(.POWER_UP_CYC(PU), .WARM_RESET_CYC(WR)) uut (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .supply_good_i(supply_good_i), .reset_n_i(reset_n_i),
    .chip_sel_n_i(chip_sel_n_i), .cold_start_ok_i(cold_start_ok_i),
    .soft_reset_cmd_i(soft_reset_cmd_i), .busy_i(busy_i), .cmd_enable_o(cmd_enable_o),
    .outputs_float_o(outputs_float_o), .abort_o(abort_o), .regs_restore_o(regs_restore_o),
    .write_enable_latch_clr_o(write_enable_latch_clr_o), .active_mode_o(active_mode_o),
    .standby_mode_o(standby_mode_o));
  sfrs_host_model host (.clk_i(clk_i), .rst_req_i(rst_req), .sel_req_i(sel_req),
    .reset_n_o(reset_n_i), .chip_sel_n_o(chip_sel_n_i));
  task automatic chk(input string nm, input int lo, input int hi, input logic [15:0] got);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask : chk
  task automatic tick;
    @(negedge clk_i);
    if (abort_o === 1'b1) ab++;
    if (regs_restore_o === 1'b1) rr++;
    if (write_enable_latch_clr_o === 1'b1) wc++;
  endtask : tick
  // bounded wait for the command gate to open
  task automatic run(output int k);
    k = 0;
    while (cmd_enable_o !== 1'b1 && k < 200) begin
      tick();
      k++;
    end
  endtask : run
  task automatic power(input logic ok, input logic hold);
    supply_good_i = 0;
    repeat (3) tick();
    cold_start_ok_i = ok;
    rst_req = hold;
    supply_good_i = 1;
  endtask : power
  task automatic t_cold;
    wc = 0;
    power(1, 1);
    repeat (10) tick();
    rst_req = 0;
    run(n);
    chk("cold time", PU, PU + 8, 16'(n + 10));
    chk("wel clear", 1, 1, 16'(wc));
    chk("standby", 1, 1, 16'(standby_mode_o));
    $display("cold done");
  endtask : t_cold
  task automatic t_active;
    sel_req = 1;
    repeat (5) tick();
    chk("active sel", 1, 1, 16'(active_mode_o));
    busy_i = 1;
    sel_req = 0;
    repeat (8) tick();
    chk("active busy", 1, 1, 16'(active_mode_o));
    busy_i = 0;
    repeat (5) tick();
    chk("standby idle", 1, 1, 16'({active_mode_o, standby_mode_o}));
    $display("active done");
  endtask : t_active
  task automatic t_warm;
    {ab, rr, wc} = 0;
    rst_req = 1;
    repeat (25) tick();
    chk("blocked", 1, 1, 16'({cmd_enable_o, outputs_float_o}));
    rst_req = 0;
    run(n);
    chk("warm time", WR, WR + 10, 16'(n + 25));
    chk("pulses", 3, 3, 16'(ab + rr + wc));
    $display("warm done");
  endtask : t_warm
  task automatic t_held;
    power(1, 1);
    repeat (PU + 30) tick();
    chk("held", 0, 0, 16'(cmd_enable_o));
    rst_req = 0;
    run(n);
    chk("held exit", 1, WR + 10, 16'(n));
    $display("held done");
  endtask : t_held
  task automatic t_fail;
    power(0, 0);
    run(n);
    rst_req = 1;
    repeat (25) tick();
    rst_req = 0;
    run(n);
    chk("pin restart", PU, PU + 15, 16'(n + 25));
    soft_reset_cmd_i = 1;
    tick();
    soft_reset_cmd_i = 0;
    tick();
    run(n);
    chk("soft restart", PU - 2, PU + 10, 16'(n));
    cold_start_ok_i = 1;
    $display("fail done");
  endtask : t_fail
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(negedge clk_i);
    sys_rst_i = 0;
    t_cold();
    t_active();
    repeat (10) tick();
    t_warm();
    t_held();
    t_fail();
    finish_test();
  end
endmodule : sfrs_sequencer_tb_top
`default_nettype wire
